/* File: rtl/port_pins_and_bit_access.sv */
// Purpose: Six-line general purpose port with bit access over APB
// Assumes: srst synchronous active high; powerOnRst only at power up
// Notes: Pads come out as out/oe/pull; the reset line is a seventh line
//
// Operation
// [RQ1] Six bidirectional lines, pull-up per line
// [RQ2] Reset puts every line in high impedance
// [RQ3] Long low on reset line requests reset
// [RQ4] Reset line reusable as weak I/O line
// [RQ5] Small variant compat mode swaps lines three, four
// [RQ6] Bit set, clear, test for indexes 0x00-0x1F
// [RQ7] Status flags clear on writing one
// [RQ8] Bit set/clear touches only the addressed bit
// [RQ9] After reset: inputs, pull-ups off
`timescale 1ns/1ps
`default_nettype none
module port_pins_and_bit_access #(
	parameter bit SMALL_VARIANT = 1'b1,
	parameter int unsigned RST_MIN_CYCLES = gpio_pkg::RST_MIN_CYCLES
) (
	// Clock and resets
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic powerOnRst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port pads
	input wire logic [gpio_pkg::PORT_LINES-1:0] portLinesIn,
	output gpio_pkg::pad_s portPad,
	// Reset line pad
	input wire logic rstPinIn,
	output logic rstPinOut,
	output logic rstPinOe,
	output logic rstPinPull,
	// System
	output logic resetReq,
	output logic irq
);
	localparam int LW = gpio_pkg::LINE_W;

	// Register state
	logic [LW-1:0] data_r;
	logic [LW-1:0] dir_r;
	logic [LW-1:0] pull_r;
	logic [LW-1:0] stat_r;
	logic [LW-1:0] mask_r;
	logic [gpio_pkg::CTRL_W-1:0] ctrl_r;
	logic [1:0] bitRes_r;
	logic [LW-1:0] prevPin_r;
	logic primed_r;

	// Line state
	logic [LW-1:0] syncPhys;
	logic [LW-1:0] pinLog;
	logic [LW-1:0] drvOut;
	logic [LW-1:0] drvOe;
	logic [LW-1:0] drvPull;
	logic rstIoEn;
	logic compatOn;
	logic [LW-1:0] pinEvt;

	// Bus state
	logic apbAccess;
	logic completing;
	logic [4:0] wordIdx;
	logic mapped;
	logic [1:0] opCode;
	logic [4:0] tgtIdx;
	logic [4:0] bitNo;
	logic [31:0] tgtVal;
	logic [31:0] oneHot;
	logic wrEn;
	logic [4:0] wrIdx;
	logic [31:0] wrVal;
	logic testEn;
	logic [LW-1:0] statClr;

	assign rstIoEn = ctrl_r[gpio_pkg::CTRL_RSTIO_BIT];
	assign compatOn = SMALL_VARIANT && ctrl_r[gpio_pkg::CTRL_COMPAT_BIT];

	// Exchange of lines three and four; the swap is its own inverse
	function automatic logic [LW-1:0] swapLines(input logic [LW-1:0] v, input logic en);
		logic [LW-1:0] r;
		r = v;
		if (en) begin
			r[gpio_pkg::SWAP_LINE_A] = v[gpio_pkg::SWAP_LINE_B];
			r[gpio_pkg::SWAP_LINE_B] = v[gpio_pkg::SWAP_LINE_A];
		end
		return r;
	endfunction

	// Register read view, shared by APB reads and bit tests
	function automatic logic [31:0] readReg(input logic [4:0] idx);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (idx)
			gpio_pkg::IDX_DATA: r[LW-1:0] = data_r;
			gpio_pkg::IDX_DIR: r[LW-1:0] = dir_r;
			gpio_pkg::IDX_PULL: r[LW-1:0] = pull_r;
			gpio_pkg::IDX_PIN: r[LW-1:0] = pinLog;
			gpio_pkg::IDX_STAT: r[LW-1:0] = stat_r;
			gpio_pkg::IDX_MASK: r[LW-1:0] = mask_r;
			gpio_pkg::IDX_CTRL: r[gpio_pkg::CTRL_W-1:0] = ctrl_r;
			gpio_pkg::IDX_BITRES: r[1:0] = bitRes_r;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// Pad inputs, reset line included, cross into clk_sys
	io_sync #(
		.W(LW),
		.RESET_VAL(gpio_pkg::SYNC_RST)
	) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.asyncIn({rstPinIn, portLinesIn}),
		.syncOut(syncPhys)
	);

	assign pinLog = swapLines(syncPhys, compatOn); // [RQ5]

	// Detection is off while the reset line serves as I/O
	rst_pulse_detect #(
		.MIN_CYCLES(RST_MIN_CYCLES)
	) u_rstDet (
		.clk_sys(clk_sys),
		.powerOnRst(powerOnRst),
		.lineLow(!syncPhys[gpio_pkg::RST_LINE]),
		.detectEn(!rstIoEn),
		.resetReq(resetReq)
	); // [RQ3]

	// APB: one wait state so read data comes from a flop
	assign apbAccess = psel && penable;
	assign completing = apbAccess && pready;
	assign wordIdx = paddr[6:2];
	assign mapped = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0) &&
		(wordIdx <= gpio_pkg::IDX_BITRES);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apbAccess && !pready;
			// Error stands only beside pready, so a stale flag is never seen
			pslverr <= apbAccess && !pready && !mapped;
			if (apbAccess && !pready) begin
				prdata <= (mapped && !pwrite) ? readReg(wordIdx) : 32'h0000_0000;
			end
		end
	end

	// Bit-access command decode
	assign opCode = pwdata[gpio_pkg::BITOP_OP_LSB +: 2];
	assign tgtIdx = pwdata[gpio_pkg::BITOP_IDX_LSB +: 5]; // [RQ6]
	assign bitNo = pwdata[gpio_pkg::BITOP_BIT_LSB +: 5];
	always_comb begin
		tgtVal = readReg(tgtIdx);
	end
	assign oneHot = 32'h0000_0001 << bitNo;

	// One write path serves plain writes and bit set/clear
	always_comb begin
		wrEn = 1'b0;
		wrIdx = wordIdx;
		wrVal = pwdata;
		testEn = 1'b0;
		if (completing && pwrite && mapped) begin
			if (wordIdx != gpio_pkg::IDX_BITOP) begin
				wrEn = 1'b1;
			end else if (opCode == gpio_pkg::OP_TEST) begin
				testEn = 1'b1; // [RQ6]
			end else if (opCode == gpio_pkg::OP_SET || opCode == gpio_pkg::OP_CLR) begin
				wrEn = 1'b1;
				wrIdx = tgtIdx;
				// Status takes a lone one or nothing, so other flags survive
				if (tgtIdx == gpio_pkg::IDX_STAT) begin
					wrVal = (opCode == gpio_pkg::OP_SET) ? oneHot : 32'h0000_0000; // [RQ8]
				end else if (opCode == gpio_pkg::OP_SET) begin
					wrVal = tgtVal | oneHot; // [RQ8]
				end else begin
					wrVal = tgtVal & ~oneHot; // [RQ8]
				end
			end
		end
	end

	// Line configuration
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			data_r <= gpio_pkg::LINES_RST;
			dir_r <= gpio_pkg::LINES_RST; // [RQ9]
			pull_r <= gpio_pkg::LINES_RST; // [RQ9]
		end else if (wrEn) begin
			if (wrIdx == gpio_pkg::IDX_DATA) begin
				data_r <= wrVal[LW-1:0];
			end
			if (wrIdx == gpio_pkg::IDX_DIR) begin
				dir_r <= wrVal[LW-1:0];
			end
			if (wrIdx == gpio_pkg::IDX_PULL) begin
				pull_r <= wrVal[LW-1:0]; // [RQ1]
			end
		end
	end

	// Mode control
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_r <= gpio_pkg::CTRL_RST;
			mask_r <= gpio_pkg::LINES_RST;
		end else if (wrEn) begin
			if (wrIdx == gpio_pkg::IDX_CTRL) begin
				ctrl_r <= wrVal[gpio_pkg::CTRL_W-1:0];
			end
			if (wrIdx == gpio_pkg::IDX_MASK) begin
				mask_r <= wrVal[LW-1:0];
			end
		end
	end

	// Bit test result: bit 0 the tested value, bit 1 a test has run
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bitRes_r <= 2'h0;
		end else if (testEn) begin
			bitRes_r <= {1'b1, |(tgtVal & oneHot)}; // [RQ6]
		end
	end

	// Pin change events; first sample after reset only primes
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prevPin_r <= gpio_pkg::LINES_RST;
			primed_r <= 1'b0;
		end else begin
			prevPin_r <= pinLog;
			primed_r <= 1'b1;
		end
	end

	assign pinEvt = primed_r ? (pinLog ^ prevPin_r) : gpio_pkg::LINES_RST;
	assign statClr = (wrEn && wrIdx == gpio_pkg::IDX_STAT) ? wrVal[LW-1:0] :
		gpio_pkg::LINES_RST;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stat_r <= gpio_pkg::LINES_RST;
		end else begin
			stat_r <= (stat_r & ~statClr) | pinEvt; // [RQ7]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_r & mask_r);
		end
	end

	// Pull-up only where the line is an input
	assign drvOut = swapLines(data_r, compatOn); // [RQ5]
	assign drvOe = swapLines(dir_r, compatOn);
	assign drvPull = swapLines(pull_r & ~dir_r, compatOn); // [RQ1]

	// Pad flops; reset leaves every enable low
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			portPad <= '0; // [RQ2]
		end else begin
			portPad.out <= drvOut[gpio_pkg::PORT_LINES-1:0];
			portPad.oe <= drvOe[gpio_pkg::PORT_LINES-1:0]; // [RQ1]
			portPad.pull <= drvPull[gpio_pkg::PORT_LINES-1:0];
		end
	end

	// Reset line: weak pad, driven only in I/O use; pulled high otherwise once srst is released (pull off while srst holds)
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rstPinOut <= 1'b0;
			rstPinOe <= 1'b0; // [RQ2]
			rstPinPull <= 1'b0;
		end else begin
			rstPinOut <= drvOut[gpio_pkg::RST_LINE];
			rstPinOe <= rstIoEn && drvOe[gpio_pkg::RST_LINE]; // [RQ4]
			rstPinPull <= rstIoEn ? drvPull[gpio_pkg::RST_LINE] : 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/gpio_pkg.sv */
// Purpose: Shared constants and types for the six-line port block
// Assumes: 32-bit APB data, 40 MHz clk_sys
// Notes: Registers are word aligned; index is byte offset / 4
package gpio_pkg;
	// Line layout: six port lines, the reset line sits on top
	localparam int PORT_LINES = 6;
	localparam int LINE_W = PORT_LINES + 1;
	localparam int RST_LINE = PORT_LINES;
	localparam int SWAP_LINE_A = 3;
	localparam int SWAP_LINE_B = 4;

	// Register byte offsets
	localparam logic [11:0] OFS_DATA = 12'h000;
	localparam logic [11:0] OFS_DIR = 12'h004;
	localparam logic [11:0] OFS_PULL = 12'h008;
	localparam logic [11:0] OFS_PIN = 12'h00C;
	localparam logic [11:0] OFS_STAT = 12'h010;
	localparam logic [11:0] OFS_MASK = 12'h014;
	localparam logic [11:0] OFS_CTRL = 12'h018;
	localparam logic [11:0] OFS_BITOP = 12'h01C;
	localparam logic [11:0] OFS_BITRES = 12'h020;

	// Register indexes as used by the bit-access command
	localparam logic [4:0] IDX_DATA = 5'(OFS_DATA >> 2);
	localparam logic [4:0] IDX_DIR = 5'(OFS_DIR >> 2);
	localparam logic [4:0] IDX_PULL = 5'(OFS_PULL >> 2);
	localparam logic [4:0] IDX_PIN = 5'(OFS_PIN >> 2);
	localparam logic [4:0] IDX_STAT = 5'(OFS_STAT >> 2);
	localparam logic [4:0] IDX_MASK = 5'(OFS_MASK >> 2);
	localparam logic [4:0] IDX_CTRL = 5'(OFS_CTRL >> 2);
	localparam logic [4:0] IDX_BITOP = 5'(OFS_BITOP >> 2);
	localparam logic [4:0] IDX_BITRES = 5'(OFS_BITRES >> 2);

	// Control register fields
	localparam int CTRL_RSTIO_BIT = 0;
	localparam int CTRL_COMPAT_BIT = 1;
	localparam int CTRL_W = 2;

	// Bit-access command fields
	localparam int BITOP_BIT_LSB = 0;
	localparam int BITOP_IDX_LSB = 8;
	localparam int BITOP_OP_LSB = 16;
	localparam logic [1:0] OP_SET = 2'h1;
	localparam logic [1:0] OP_CLR = 2'h2;
	localparam logic [1:0] OP_TEST = 2'h3;

	// Values after reset
	localparam logic [LINE_W-1:0] LINES_RST = 7'h00;
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
	localparam logic [LINE_W-1:0] SYNC_RST = 7'h40;

	// Reset pin pulse timing
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned RST_MIN_PULSE_NS = 2500;
	localparam int unsigned RST_MIN_CYCLES =
		(RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Pad drive bundle for the six port lines
	typedef struct packed {
		logic [PORT_LINES-1:0] out;
		logic [PORT_LINES-1:0] oe;
		logic [PORT_LINES-1:0] pull;
	} pad_s;
endpackage

/* File: rtl/io_sync.sv */
// Purpose: Two-stage synchroniser for pad inputs
// Assumes: Inputs are asynchronous to clk_sys
// Notes: Only the second stage may be read
`timescale 1ns/1ps
`default_nettype none
module io_sync #(
	parameter int W = 7,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Data
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] stage1_r;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stage1_r <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else begin
			stage1_r <= asyncIn;
			syncOut <= stage1_r;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/rst_pulse_detect.sv */
// Purpose: Reset request from a long enough low level on the reset line
// Assumes: lineLow is already synchronised
// Notes: Runs on its own reset so the request it raises cannot cancel it
`timescale 1ns/1ps
`default_nettype none
module rst_pulse_detect #(
	parameter int unsigned MIN_CYCLES = gpio_pkg::RST_MIN_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic powerOnRst,
	// Line
	input wire logic lineLow,
	input wire logic detectEn,
	// Request
	output logic resetReq
);
	localparam int CW = $clog2(MIN_CYCLES + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYCLES);

	logic [CW-1:0] lowCnt_r;

	always_ff @(posedge clk_sys) begin
		if (powerOnRst || !detectEn || !lineLow) begin
			lowCnt_r <= '0;
		end else if (lowCnt_r != CNT_MAX) begin
			lowCnt_r <= lowCnt_r + CW'(1);
		end
	end

	// Short pulses never reach the count
	always_ff @(posedge clk_sys) begin
		if (powerOnRst) begin
			resetReq <= 1'b0;
		end else begin
			resetReq <= detectEn && lineLow && (lowCnt_r == CNT_MAX);
		end
	end
endmodule
`default_nettype wire

/* File: testbench/port_pins_and_bit_access_props.sv */
// Purpose: Bus and pad checks for the port block
// Assumes: Bound to the top module, one clock domain
// Notes: Lines three and four are left out of the data check since compat mode swaps them
`timescale 1ns/1ps
`default_nettype none
module port_pins_props #(
	parameter int unsigned RST_MIN_CYCLES = 4
) (
	// Clock and resets
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic powerOnRst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pads and system
	input wire gpio_pkg::pad_s portPad,
	input wire logic rstPinIn,
	input wire logic rstPinOe,
	input wire logic resetReq
);
	int lowCnt_r;
	logic [31:0] dataW_r;
	wire logic accStart = psel && penable && !pready;
	wire logic wrDone = psel && penable && pready && pwrite;

	// Saturates so a long hold cannot wrap
	always_ff @(posedge clk_sys) begin
		if (rstPinIn)
			lowCnt_r <= 0;
		else if (lowCnt_r < 1000)
			lowCnt_r <= lowCnt_r + 1;
	end
	always_ff @(posedge clk_sys) begin
		if (wrDone)
			dataW_r <= pwdata;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_pull_drive_excl: assert property ((portPad.pull & portPad.oe) == '0)
		else $error("pull-up on a driven line");
	a_reset_tristate: assert property (disable iff (1'b0) srst |=> portPad.oe == '0 && !rstPinOe)
		else $error("line driven after reset");
	a_reset_inputs: assert property (disable iff (1'b0) srst |=> portPad.pull == '0 && portPad.out == '0)
		else $error("pull or data set after reset");
	a_ready_once: assert property (accStart |=> pready ##1 !pready)
		else $error("ready not a single pulse after access");
	a_bad_addr_err: assert property (accStart && (paddr[1:0] != 2'h0 || paddr >= 12'h024)
		|=> pslverr && prdata == '0)
		else $error("bad address not refused");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_data_to_pad: assert property (wrDone && paddr == gpio_pkg::OFS_DATA |=> ##1
		portPad.out[2:0] == dataW_r[2:0] && portPad.out[5] == dataW_r[5])
		else $error("pad out does not follow data");
	a_req_min_low: assert property (disable iff (powerOnRst)
		$rose(resetReq) |-> lowCnt_r >= RST_MIN_CYCLES)
		else $error("reset request after a short low");
	a_req_release: assert property (disable iff (powerOnRst) rstPinIn [*4] |=> !resetReq)
		else $error("reset request with line high");
endmodule

bind port_pins_and_bit_access port_pins_props #(.RST_MIN_CYCLES(RST_MIN_CYCLES)) props_u (
	.clk_sys(clk_sys), .srst(srst), .powerOnRst(powerOnRst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .portPad(portPad), .rstPinIn(rstPinIn), .rstPinOe(rstPinOe),
	.resetReq(resetReq));
`default_nettype wire

/* File: testbench/port_ext_model.sv */
// Purpose: Circuitry on the far side of the port pads
// Assumes: Bench never drives a line the block drives
// Notes: A floating line shows the inverse of its last driven level
`timescale 1ns/1ps
`default_nettype none
module port_ext_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Pads from the block
	input wire gpio_pkg::pad_s portPad,
	input wire logic rstPinOut,
	input wire logic rstPinOe,
	input wire logic rstPinPull,
	// Far side controls
	input wire logic [5:0] extVal,
	input wire logic [5:0] extDrv,
	input wire logic rstLow,
	// Wire levels
	output logic [5:0] portLinesIn,
	output logic rstPinIn
);
	logic [6:0] last_r = 7'h00;
	wire logic [5:0] held = portPad.oe | extDrv | portPad.pull;

	// Block drive, then far side, then pull-up, else floating
	assign portLinesIn = (portPad.oe & portPad.out) | (~portPad.oe & extDrv & extVal)
		| (~portPad.oe & ~extDrv & portPad.pull) | (~held & ~last_r[5:0]);
	assign rstPinIn = rstPinOe ? rstPinOut : rstLow ? 1'b0 : rstPinPull ? 1'b1 : ~last_r[6];
	always_ff @(posedge clk_sys) begin
		// Pads are unknown until reset has set them, so no level is kept then
		if (!srst) begin
			last_r[5:0] <= (held & portLinesIn) | (~held & last_r[5:0]);
			last_r[6] <= (rstPinOe || rstLow || rstPinPull) ? rstPinIn : last_r[6];
		end
	end
endmodule
`default_nettype wire

/* File: testbench/port_pins_and_bit_access_tb_top.sv */
// Purpose: Self-checking bench for the port block
// Assumes: Reset line detector threshold shortened to 4
// Notes: Reads queue their expected word; a monitor compares at pready
`timescale 1ns/1ps
`default_nettype none
module port_pins_and_bit_access_tb_top;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic powerOnRst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, rstPinIn, rstPinOut, rstPinOe, rstPinPull, resetReq, irq;
	logic [5:0] portLinesIn;
	gpio_pkg::pad_s portPad;
	logic [5:0] extVal = 6'h00;
	logic [5:0] extDrv = 6'h00;
	logic rstLow = 1'b0;
	logic [32:0] expQ[$];
	logic [31:0] seed = 32'hB0073BEC;
	logic [5:0] v;
	int err_count = 0;
	int n_checks = 0;

	always #12.5 clk_sys = ~clk_sys;

	port_pins_and_bit_access #(.SMALL_VARIANT(1'b1), .RST_MIN_CYCLES(4)) dut_u (
		.clk_sys(clk_sys), .srst(srst), .powerOnRst(powerOnRst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .portLinesIn(portLinesIn), .portPad(portPad),
		.rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
		.rstPinPull(rstPinPull), .resetReq(resetReq), .irq(irq));
	port_ext_model ext_u (.clk_sys(clk_sys), .srst(srst), .portPad(portPad),
		.rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .rstPinPull(rstPinPull),
		.extVal(extVal), .extDrv(extDrv), .rstLow(rstLow), .portLinesIn(portLinesIn),
		.rstPinIn(rstPinIn));

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	function automatic logic [31:0] bop(input logic [1:0] op, input logic [4:0] idx, input int b);
		return (32'(op) << gpio_pkg::BITOP_OP_LSB) | (32'(idx) << gpio_pkg::BITOP_IDX_LSB) | 32'(b);
	endfunction
	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		expQ.push_back(x);
		apb(1'b0, a, 32'h00000000);
	endtask

	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check("prdata", {pslverr, prdata}, expQ.pop_front());
	end

	initial begin
		#1000000;
		err_count++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		powerOnRst <= 1'b0;
		@(posedge clk_sys);
		check("padOe", portPad.oe, 33'h0);
		check("padPull", portPad.pull, 33'h0);
		rd(gpio_pkg::OFS_DIR, 33'h0);
		rd(gpio_pkg::OFS_PULL, 33'h0);
		seed = xs(seed);
		v = seed[5:0];
		apb(1'b1, gpio_pkg::OFS_DIR, 32'h3F);
		apb(1'b1, gpio_pkg::OFS_DATA, seed);
		// Pads update on the edge that ends the task, so look half a cycle on
		@(negedge clk_sys);
		check("padOut", portPad.out, 33'(v));
		check("padOe", portPad.oe, 33'h3F);
		@(posedge clk_sys);
		rd(gpio_pkg::OFS_PIN, 33'h40 | 33'(v));
		apb(1'b1, gpio_pkg::OFS_DIR, 32'h0);
		extDrv <= 6'h2A;
		apb(1'b1, gpio_pkg::OFS_PULL, 32'h15);
		@(negedge clk_sys);
		check("padPull", portPad.pull, 33'h15);
		@(posedge clk_sys);
		rd(gpio_pkg::OFS_PIN, 33'h55);
		apb(1'b1, gpio_pkg::OFS_DIR, 32'h1);
		@(negedge clk_sys);
		check("padPull", portPad.pull, 33'h14);
		@(posedge clk_sys);
		apb(1'b1, gpio_pkg::OFS_BITOP, bop(gpio_pkg::OP_SET, gpio_pkg::IDX_DATA, 1));
		apb(1'b1, gpio_pkg::OFS_BITOP, bop(gpio_pkg::OP_CLR, gpio_pkg::IDX_DATA, 0));
		// DATA keeps seven bits, the reset line's bit included
		rd(gpio_pkg::OFS_DATA, 33'((seed[6:0] | 7'h02) & 7'h7E));
		apb(1'b1, gpio_pkg::OFS_BITOP, bop(gpio_pkg::OP_TEST, gpio_pkg::IDX_DATA, 1));
		rd(gpio_pkg::OFS_BITRES, 33'h3);
		apb(1'b1, gpio_pkg::OFS_BITOP, bop(gpio_pkg::OP_TEST, gpio_pkg::IDX_DATA, 0));
		rd(gpio_pkg::OFS_BITRES, 33'h2);
		apb(1'b1, gpio_pkg::OFS_STAT, 32'h7F);
		rd(gpio_pkg::OFS_STAT, 33'h0);
		apb(1'b1, gpio_pkg::OFS_MASK, 32'h2);
		extVal <= 6'h02;
		repeat (6) @(posedge clk_sys);
		check("irq", irq, 33'h1);
		apb(1'b1, gpio_pkg::OFS_STAT, 32'h0);
		apb(1'b1, gpio_pkg::OFS_BITOP, bop(gpio_pkg::OP_CLR, gpio_pkg::IDX_STAT, 1));
		rd(gpio_pkg::OFS_STAT, 33'h2);
		apb(1'b1, gpio_pkg::OFS_MASK, 32'h0);
		@(negedge clk_sys);
		check("irq", irq, 33'h0);
		@(posedge clk_sys);
		apb(1'b1, gpio_pkg::OFS_MASK, 32'h2);
		apb(1'b1, gpio_pkg::OFS_BITOP, bop(gpio_pkg::OP_SET, gpio_pkg::IDX_STAT, 1));
		rd(gpio_pkg::OFS_STAT, 33'h0);
		check("irq", irq, 33'h0);
		rd(12'h024, {1'b1, 32'h0});
		rd(12'h006, {1'b1, 32'h0});
		rd(12'h080, {1'b1, 32'h0});
		// Held well past the threshold since the sync stages add delay
		rstLow <= 1'b1;
		repeat (10) @(posedge clk_sys);
		check("resetReq", resetReq, 33'h1);
		rstLow <= 1'b0;
		repeat (6) @(posedge clk_sys);
		check("resetReq", resetReq, 33'h0);
		apb(1'b1, gpio_pkg::OFS_CTRL, 32'h1);
		apb(1'b1, gpio_pkg::OFS_DIR, 32'h40);
		apb(1'b1, gpio_pkg::OFS_DATA, 32'h0);
		repeat (8) @(posedge clk_sys);
		check("rstPin", {rstPinPull, rstPinOe, rstPinOut, resetReq}, 33'h4);
		extDrv <= 6'h00;
		apb(1'b1, gpio_pkg::OFS_CTRL, 32'h2);
		apb(1'b1, gpio_pkg::OFS_DIR, 32'h3F);
		apb(1'b1, gpio_pkg::OFS_DATA, 32'h8);
		@(negedge clk_sys);
		check("padOut", portPad.out, 33'h10);
		@(posedge clk_sys);
		srst <= 1'b1;
		@(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		check("padOe", portPad.oe, 33'h0);
		check("padPull", portPad.pull, 33'h0);
		finish_test();
	end
endmodule
`default_nettype wire
